/* File: mqr_params.svh */
`ifndef MQR_PARAMS_SVH
`define MQR_PARAMS_SVH

// Queue count and address layout
`define MQR_NQ        4
`define MQR_NULL_BIT  2
`define MQR_RTAG_LSB  3
`define MQR_WTAG_LSB  2

// Storage and flag thresholds, in 9-bit bytes and port units
`define MQR_DEPTH     1024
`define MQR_AE_LEVEL  8
`define MQR_AF_LEVEL  8

// Register byte offsets and control register reset value
`define MQR_REG_CTRL  6'h00
`define MQR_REG_STAT  6'h04
`define MQR_REG_LVL0  6'h08
`define MQR_REG_LVL3  6'h14
`define MQR_CTRL_RST  4'h0

// Status field positions
`define MQR_ST_RQID   0
`define MQR_ST_RNULL  2
`define MQR_ST_RACT   3
`define MQR_ST_WQID   4
`define MQR_ST_WACT   6
`define MQR_ST_RD18   7
`define MQR_ST_WR18   8
`define MQR_ST_VALID  9

`endif

/* File: mqr_pkg.sv */
package mqr_pkg;

  typedef logic [1:0] mqr_qid_t;
  typedef logic [2:0] mqr_tag_t;

  typedef enum logic [2:0] {
    MQR_SEL_IDLE = 3'h1,
    MQR_SEL_OLD  = 3'h2,
    MQR_SEL_NEW  = 3'h4
  } mqr_sel_e;

  typedef struct packed {
    mqr_qid_t qid;
    logic     nul;
    logic     act;
  } mqr_sel_s;

  typedef struct packed {
    mqr_sel_e st;
    mqr_sel_s cur;
    mqr_sel_s pend;
  } mqr_trk_s;

  typedef struct packed {
    logic [17:0] rdata;
    logic        valid_n;
    logic        doe_n;
    logic        wv_oe_n;
    logic        aoe_n;
    logic [3:0]  ae_n;
    logic        foe_n;
    logic [3:0]  af_n;
    logic        full_n;
    logic        wr18;
    logic        rd18;
    logic        waitreq;
    logic [31:0] rdd;
    logic [3:0]  clr;
  } mqr_top_s;

  function automatic logic mqr_tag_hit(input mqr_tag_t a, input mqr_tag_t t);
    return a == t;
  endfunction : mqr_tag_hit

endpackage : mqr_pkg

/* File: mqr_store_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface mqr_store_if #(parameter int CW = 11);
  logic                  push;
  mqr_pkg::mqr_qid_t     push_qid;
  logic                  push_two;
  logic [17:0]           push_data;
  logic                  pop;
  mqr_pkg::mqr_qid_t     pop_qid;
  logic                  pop_two;
  logic [17:0]           peek_data;
  logic [3:0]            clear;
  logic [3:0][CW-1:0]    level;

  modport store (input push, push_qid, push_two, push_data, pop, pop_qid, pop_two, clear,
                 output peek_data, level);
  modport user  (output push, push_qid, push_two, push_data, pop, pop_qid, pop_two, clear,
                 input peek_data, level);
endinterface : mqr_store_if

`default_nettype wire

/* File: mqr_sel_track.sv */
`timescale 1ns/1ps
`default_nettype none

module mqr_sel_track (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             nrst,
  // Selection request
  input  wire logic             strobe,
  input  wire mqr_pkg::mqr_qid_t qid,
  input  wire logic             null_sel,
  input  wire logic             tag_ok,
  // Queue used at the current edge
  output mqr_pkg::mqr_sel_s     src
);
  import mqr_pkg::*;

  mqr_trk_s q;
  mqr_trk_s d;

  always_comb begin
    d = q;
    case (q.st)
      MQR_SEL_OLD: begin
        d.st = MQR_SEL_NEW;
      end
      MQR_SEL_NEW: begin
        d.st  = MQR_SEL_IDLE;
        d.cur = q.pend;
      end
      default: begin
        d.st = MQR_SEL_IDLE;
      end
    endcase
    // A second strobe one edge after a selection is dropped
    if (strobe && q.st != MQR_SEL_OLD) begin // RULE1 RULE3
      if (q.st == MQR_SEL_NEW) begin
        d.cur = q.pend;
      end
      d.st       = MQR_SEL_OLD;
      d.pend.qid = qid;
      d.pend.nul = null_sel | ~tag_ok; // RULE10 RULE11
      d.pend.act = tag_ok;
    end
    if (!nrst) begin
      d         = '0;
      d.st      = MQR_SEL_IDLE;
      d.cur.nul = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    q <= d;
  end

  // Old queue serves the selection edge and the next one
  assign src = (q.st == MQR_SEL_NEW) ? q.pend : q.cur; // RULE2 RULE5

endmodule : mqr_sel_track

`default_nettype wire

/* File: mqr_queue_mem.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mqr_params.svh"

module mqr_queue_mem #(
  parameter int DEPTH = `MQR_DEPTH
) (
  // Clock and reset
  input wire logic  clock,
  input wire logic  nrst,
  // Store side
  mqr_store_if.store st
);
  import mqr_pkg::*;

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [3:0][AW-1:0] wp;
    logic [3:0][AW-1:0] rp;
    logic [3:0][AW:0]   cnt;
  } mqr_ptr_s;

  // Byte-wide storage so both port widths share one layout
  logic [8:0] mem [`MQR_NQ][DEPTH];
  mqr_ptr_s   q;
  mqr_ptr_s   d;

  always_comb begin
    logic [AW:0] inc;
    logic [AW:0] dec;
    inc = '0;
    dec = '0;
    d   = q;
    for (int i = 0; i < `MQR_NQ; i++) begin
      inc = (st.push && st.push_qid == mqr_qid_t'(i)) ? (st.push_two ? (AW+1)'(2) : (AW+1)'(1))
                                                      : '0;
      dec = (st.pop && st.pop_qid == mqr_qid_t'(i)) ? (st.pop_two ? (AW+1)'(2) : (AW+1)'(1))
                                                    : '0;
      if (st.clear[i]) begin
        d.wp[i]  = '0;
        d.rp[i]  = '0;
        d.cnt[i] = '0;
      end else begin
        d.wp[i]  = q.wp[i] + inc[AW-1:0];
        d.rp[i]  = q.rp[i] + dec[AW-1:0];
        d.cnt[i] = q.cnt[i] + inc - dec;
      end
    end
    if (!nrst) begin
      d = '0;
    end
  end

  always_ff @(posedge clock) begin
    q <= d;
    // Low byte first: little-endian packing
    if (st.push) begin // RULE17
      mem[st.push_qid][q.wp[st.push_qid]] <= st.push_data[8:0];
      if (st.push_two) begin
        mem[st.push_qid][q.wp[st.push_qid] + AW'(1)] <= st.push_data[17:9];
      end
    end
  end

  assign st.peek_data = {mem[st.pop_qid][q.rp[st.pop_qid] + AW'(1)],
                         mem[st.pop_qid][q.rp[st.pop_qid]]};
  assign st.level     = q.cnt;

endmodule : mqr_queue_mem

`default_nettype wire

/* File: mqr_read_port.sv */
// Functional notes
// RULE1: Strobe high at a clock edge takes the read address as new queue.
// RULE2: One selection edge suffices; reads stay on that queue until reselected.
// RULE3: Controller spaces read queue selections at least two clocks apart.
// RULE4: First word of a non-empty new queue lands two edges after selection.
// RULE5: Selection edge and next edge still read the previous queue.
// RULE6: Output enable only gates drive; the output register still loads.
// RULE7: Old queue last word and new queue first word leave consecutively.
// RULE8: Empty new queue: old reads finish, then word held and valid drops.
// RULE9: Six-bit read address: two queue bits, a null bit, three tag bits.
// RULE10: Only a selection whose tag equals the chip tag pins is served.
// RULE11: Null bit set selects an always-empty queue; low bits ignored.
// RULE12: Null queue flushes the old queue's words and may stay selected.
// RULE13: The null queue exists on the read port only.
// RULE14: Empty bus strobe with address strobe low picks the flag bus driver.
// RULE15: Reads stopping at empty leave the last word in the output register.
// RULE16: Width pins sampled at reset set x18 or x9 for each port.
// RULE17: Mixed widths pack 9-bit bytes into 18-bit words little-endian.
// RULE18: Full and almost-full flags count in write-port units.
// RULE19: Valid and almost-empty flags count in read-port units.
// RULE20: Every queue shares one write width and one read width.
// RULE21: Five-bit write address: two queue bits, three tag bits.
// RULE22: Valid flag goes inactive at the enabled edge after the last word.
// RULE23: With read enable high the output word and valid flag hold.
`timescale 1ns/1ps
`default_nettype none
`include "mqr_params.svh"

module mqr_read_port #(
  parameter int DEPTH    = `MQR_DEPTH,
  parameter int AE_LEVEL = `MQR_AE_LEVEL,
  parameter int AF_LEVEL = `MQR_AF_LEVEL
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // Chip tag and width straps
  input  wire logic        chip_tag_bit0,
  input  wire logic        chip_tag_bit1,
  input  wire logic        chip_tag_bit2,
  input  wire logic        write_width_select,
  input  wire logic        read_width_select,
  // Write port
  input  wire logic [4:0]  write_queue_address,
  input  wire logic        write_address_strobe,
  input  wire logic        full_flag_bus_strobe,
  input  wire logic        write_enable_n,
  input  wire logic [17:0] write_data,
  // Read port
  input  wire logic [5:0]  read_queue_address,
  input  wire logic        read_address_strobe,
  input  wire logic        empty_flag_bus_strobe,
  input  wire logic        read_enable_n,
  input  wire logic        output_enable_n,
  output logic [17:0]      read_data,
  output logic             read_data_oe_n,
  output logic             word_valid_flag_n,
  output logic             word_valid_oe_n,
  // Flags
  output logic             full_flag_n,
  output logic [3:0]       almost_empty_flag_bus_n,
  output logic             almost_empty_bus_oe_n,
  output logic [3:0]       almost_full_flag_bus_n,
  output logic             almost_full_bus_oe_n,
  // Avalon-MM slave
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest
);
  import mqr_pkg::*;

  localparam int CW = $clog2(DEPTH) + 1;

  mqr_top_s q;
  mqr_top_s d;

  mqr_sel_s    rsrc;
  mqr_sel_s    wsrc;
  mqr_tag_t    tag;
  logic [CW-1:0] rlvl;
  logic [CW-1:0] wlvl;
  logic        rempty;
  logic        wroom;
  logic        rd_go;
  logic [2:0]  lidx;

  mqr_store_if #(.CW(CW)) sif ();

  assign tag = {chip_tag_bit2, chip_tag_bit1, chip_tag_bit0};

  // Read and write ports track their selections separately
  mqr_sel_track u_rd_track (
    .clock    (clock),
    .nrst     (nrst),
    .strobe   (read_address_strobe),
    .qid      (read_queue_address[1:0]),
    .null_sel (read_queue_address[`MQR_NULL_BIT]),
    .tag_ok   (mqr_tag_hit(read_queue_address[5:`MQR_RTAG_LSB], tag)),
    .src      (rsrc)
  ); // RULE1 RULE9 RULE10 RULE11

  mqr_sel_track u_wr_track (
    .clock    (clock),
    .nrst     (nrst),
    .strobe   (write_address_strobe),
    .qid      (write_queue_address[1:0]),
    .null_sel (1'b0),
    .tag_ok   (mqr_tag_hit(write_queue_address[4:`MQR_WTAG_LSB], tag)),
    .src      (wsrc)
  ); // RULE13 RULE21

  mqr_queue_mem #(
    .DEPTH (DEPTH)
  ) u_mem (
    .clock (clock),
    .nrst  (nrst),
    .st    (sif.store)
  );

  assign rlvl = sif.level[rsrc.qid];
  assign wlvl = sif.level[wsrc.qid];

  // Empty and room are judged in each port's own unit
  assign rempty = rsrc.nul | (rlvl < (q.rd18 ? CW'(2) : CW'(1))); // RULE11 RULE19
  assign wroom  = (CW'(DEPTH) - wlvl) >= (q.wr18 ? CW'(2) : CW'(1)); // RULE18
  assign rd_go  = ~read_enable_n & ~rempty & rsrc.act;

  // Write side: one width for every queue
  assign sif.push      = ~write_enable_n & wsrc.act & wroom; // RULE20 RULE21
  assign sif.push_qid  = wsrc.qid;
  assign sif.push_two  = q.wr18;
  assign sif.push_data = q.wr18 ? write_data : {9'h000, write_data[8:0]}; // RULE17

  // Read side pops straight into the output register
  assign sif.pop     = rd_go;
  assign sif.pop_qid = rsrc.qid;
  assign sif.pop_two = q.rd18;
  assign sif.clear   = q.clr;

  assign lidx = avs_address[4:2] - 3'h2;

  always_comb begin
    logic [CW-1:0] ulvl;
    logic [CW-1:0] free;
    ulvl = '0;
    free = '0;
    d    = q;
    d.clr = '0;

    // Output register and valid flag
    if (!read_enable_n) begin // RULE23
      if (rd_go) begin // RULE4 RULE5 RULE7 RULE15
        d.rdata   = q.rd18 ? sif.peek_data : {9'h000, sif.peek_data[8:0]}; // RULE17 RULE20
        d.valid_n = 1'b0;
      end else begin
        // Word stays, only the flag changes
        d.valid_n = 1'b1; // RULE8 RULE11 RULE12 RULE22
      end
    end

    // Drive enables; loading above ignores them
    d.doe_n   = output_enable_n | ~rsrc.act; // RULE6
    d.wv_oe_n = ~rsrc.act;

    // Flag bus device selection
    if (!read_address_strobe && empty_flag_bus_strobe) begin // RULE14
      d.aoe_n = ~mqr_tag_hit(read_queue_address[5:`MQR_RTAG_LSB], tag);
    end
    if (!write_address_strobe && full_flag_bus_strobe) begin
      d.foe_n = ~mqr_tag_hit(write_queue_address[4:`MQR_WTAG_LSB], tag);
    end

    // Per-queue flags in port units
    for (int i = 0; i < `MQR_NQ; i++) begin
      ulvl = q.rd18 ? (sif.level[i] >> 1) : sif.level[i]; // RULE19
      d.ae_n[i] = ulvl > CW'(AE_LEVEL);
      free = CW'(DEPTH) - sif.level[i];
      ulvl = q.wr18 ? (free >> 1) : free; // RULE18
      d.af_n[i] = ulvl > CW'(AF_LEVEL);
    end
    d.full_n = wroom; // RULE18

    // Avalon-MM: one wait state, then answer
    if ((avs_read || avs_write) && q.waitreq) begin
      d.waitreq = 1'b0;
      d.rdd     = '0;
      if (avs_address == `MQR_REG_CTRL) begin
        d.rdd[3:0] = q.clr;
      end else if (avs_address == `MQR_REG_STAT) begin
        d.rdd[`MQR_ST_RQID +: 2] = rsrc.qid;
        d.rdd[`MQR_ST_RNULL]     = rsrc.nul;
        d.rdd[`MQR_ST_RACT]      = rsrc.act;
        d.rdd[`MQR_ST_WQID +: 2] = wsrc.qid;
        d.rdd[`MQR_ST_WACT]      = wsrc.act;
        d.rdd[`MQR_ST_RD18]      = q.rd18;
        d.rdd[`MQR_ST_WR18]      = q.wr18;
        d.rdd[`MQR_ST_VALID]     = ~q.valid_n;
      end else if (avs_address >= `MQR_REG_LVL0 && avs_address <= `MQR_REG_LVL3
                   && avs_address[1:0] == 2'h0) begin
        d.rdd = 32'(sif.level[lidx[1:0]]);
      end else begin
        d.rdd = '0;
      end
    end else begin
      d.waitreq = 1'b1;
    end

    // Writes land on the edge that sees waitrequest low
    if (avs_write && !q.waitreq && avs_address == `MQR_REG_CTRL && avs_byteenable[0]) begin
      d.clr = avs_writedata[3:0];
    end

    // Synchronous reset also samples the width straps
    if (!nrst) begin
      d         = '0;
      d.valid_n = 1'b1;
      d.doe_n   = 1'b1;
      d.wv_oe_n = 1'b1;
      d.aoe_n   = 1'b1;
      d.foe_n   = 1'b1;
      d.ae_n    = 4'hF;
      d.af_n    = 4'hF;
      d.full_n  = 1'b1;
      d.waitreq = 1'b1;
      d.clr     = `MQR_CTRL_RST;
      d.wr18    = ~write_width_select; // RULE16
      d.rd18    = ~read_width_select; // RULE16
    end
  end

  always_ff @(posedge clock) begin
    q <= d;
  end

  assign read_data               = q.rdata;
  assign read_data_oe_n          = q.doe_n;
  assign word_valid_flag_n       = q.valid_n;
  assign word_valid_oe_n         = q.wv_oe_n;
  assign full_flag_n             = q.full_n;
  assign almost_empty_flag_bus_n = q.ae_n;
  assign almost_empty_bus_oe_n   = q.aoe_n;
  assign almost_full_flag_bus_n  = q.af_n;
  assign almost_full_bus_oe_n    = q.foe_n;
  assign avs_readdata            = q.rdd;
  assign avs_waitrequest         = q.waitreq;

endmodule : mqr_read_port

`default_nettype wire

/* File: mqr_read_port_properties.sv */
`timescale 1ns/1ps
`default_nettype none

module mqr_read_port_chk (
  // Clock and reset
  input wire logic        clock,
  input wire logic        nrst,
  // Straps
  input wire logic        chip_tag_bit0,
  input wire logic        chip_tag_bit1,
  input wire logic        chip_tag_bit2,
  input wire logic        read_width_select,
  // Write side
  input wire logic [4:0]  write_queue_address,
  input wire logic        write_address_strobe,
  input wire logic        full_flag_bus_strobe,
  // Read side
  input wire logic [5:0]  read_queue_address,
  input wire logic        read_address_strobe,
  input wire logic        empty_flag_bus_strobe,
  input wire logic        read_enable_n,
  input wire logic        output_enable_n,
  input wire logic [17:0] read_data,
  input wire logic        read_data_oe_n,
  input wire logic        word_valid_flag_n,
  input wire logic        word_valid_oe_n,
  input wire logic        almost_empty_bus_oe_n,
  input wire logic        almost_full_bus_oe_n,
  input wire logic [3:0]  almost_empty_flag_bus_n,
  // Register bus
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest
);
  logic [2:0] tag;
  assign tag = {chip_tag_bit2, chip_tag_bit1, chip_tag_bit0};

  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence s_null_pick;
    read_address_strobe && !$past(read_address_strobe) && read_queue_address[2]
      && read_queue_address[5:3] == tag;
  endsequence
  sequence s_null_read;
    s_null_pick ##2 !read_enable_n;
  endsequence

  property p_hold;
    $past(nrst) && $past(read_enable_n) |-> $stable(read_data) && $stable(word_valid_flag_n);
  endproperty
  property p_oe;
    !read_data_oe_n |-> $past(nrst) && !$past(output_enable_n);
  endproperty
  property p_tag;
    read_address_strobe && !$past(read_address_strobe) && read_queue_address[5:3] != tag
      |-> ##[1:3] word_valid_oe_n;
  endproperty
  property p_ae;
    empty_flag_bus_strobe && !read_address_strobe
      |=> almost_empty_bus_oe_n == ($past(read_queue_address[5:3]) != tag);
  endproperty
  property p_af;
    full_flag_bus_strobe && !write_address_strobe
      |=> almost_full_bus_oe_n == ($past(write_queue_address[4:2]) != tag);
  endproperty
  property p_null;
    s_null_read |=> word_valid_flag_n && $stable(read_data);
  endproperty
  property p_x9;
    read_width_select |-> read_data[17:9] == 9'h000;
  endproperty
  property p_wait;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  // Reset values must show even while reset is still held
  property p_rst;
    disable iff (1'b0) !nrst |=> read_data == 18'h00000 && word_valid_flag_n
      && almost_empty_flag_bus_n == 4'hF && avs_waitrequest;
  endproperty

  a_hold: assert property (p_hold) else $error("output word moved without read enable");
  a_oe: assert property (p_oe) else $error("data driven without output enable");
  a_tag: assert property (p_tag) else $error("foreign tag did not deselect");
  a_ae: assert property (p_ae) else $error("empty flag bus drive wrong");
  a_af: assert property (p_af) else $error("full flag bus drive wrong");
  a_null: assert property (p_null) else $error("null queue gave a word");
  a_x9: assert property (p_x9) else $error("upper byte set in narrow read");
  a_wait: assert property (p_wait) else $error("register bus wait state wrong");
  a_rst: assert property (p_rst) else $error("reset value wrong");
endmodule : mqr_read_port_chk

bind mqr_read_port mqr_read_port_chk u_chk (.*);

`default_nettype wire

/* File: mqr_rd_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none

module mqr_rd_ctrl (
  // Clock
  input  wire logic       clock,
  // Bench requests
  input  wire logic       go,
  input  wire logic       flag_op,
  input  wire logic [5:0] addr,
  // Read selection pins
  output var  logic       read_address_strobe,
  output var  logic       empty_flag_bus_strobe,
  output var  logic [5:0] read_queue_address
);
  initial begin
    read_address_strobe = 1'b0;
    empty_flag_bus_strobe = 1'b0;
    read_queue_address = 6'h00;
  end

  always @(posedge clock) begin
    // Refuses a request one edge after a strobe
    if (go && !read_address_strobe && !empty_flag_bus_strobe) begin
      read_address_strobe <= !flag_op;
      empty_flag_bus_strobe <= flag_op;
      read_queue_address <= addr;
    end else begin
      read_address_strobe <= 1'b0;
      empty_flag_bus_strobe <= 1'b0;
      // Idle address toggles so no stale value is trusted
      read_queue_address <= ~read_queue_address;
    end
  end
endmodule : mqr_rd_ctrl

`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic clock, nrst, chip_tag_bit0, chip_tag_bit1, chip_tag_bit2;
  logic write_width_select, read_width_select, write_address_strobe, full_flag_bus_strobe;
  logic write_enable_n, read_address_strobe, empty_flag_bus_strobe, read_enable_n;
  logic output_enable_n, read_data_oe_n, word_valid_flag_n, word_valid_oe_n, full_flag_n;
  logic almost_empty_bus_oe_n, almost_full_bus_oe_n, avs_read, avs_write, avs_waitrequest;
  logic go, flag_op, rd_on;
  logic [2:0]  tg;
  logic [4:0]  write_queue_address;
  logic [5:0]  read_queue_address, avs_address, addr;
  logic [17:0] write_data, read_data;
  logic [3:0]  almost_empty_flag_bus_n, almost_full_flag_bus_n, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata;
  logic [8:0]  mq[4][$];
  logic [17:0] exp_q[$];
  int          fail_count, checked, cnt, src, pend;

  assign {chip_tag_bit2, chip_tag_bit1, chip_tag_bit0} = tg;
  assign avs_byteenable = 4'hF;

  mqr_read_port #(.DEPTH(16), .AE_LEVEL(2), .AF_LEVEL(2)) DUT (.*);
  mqr_rd_ctrl u_ctrl (.*);

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic final_report();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge clock);
      n++;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n == 50) fail_count++;
    @(posedge clock);
  endtask : bus

  task automatic wr(input logic [2:0] t, input logic [1:0] q, input int n);
    logic [17:0] d;
    write_queue_address <= {t, q};
    write_address_strobe <= 1'b1;
    @(posedge clock);
    write_address_strobe <= 1'b0;
    repeat (2) @(posedge clock);
    for (int i = 0; i < n; i++) begin
      d = 18'($urandom);
      write_data <= d;
      write_enable_n <= 1'b0;
      @(posedge clock);
      if (t == tg) mq[q].push_back(d[8:0]);
      if (t == tg && !write_width_select) mq[q].push_back(d[17:9]);
    end
    write_enable_n <= 1'b1;
  endtask : wr

  task automatic sel(input logic f, input logic [5:0] a, input int w);
    go <= 1'b1;
    flag_op <= f;
    addr <= a;
    @(posedge clock);
    go <= 1'b0;
    repeat (w) @(posedge clock);
  endtask : sel

  // Reference read pipeline: two edges of old queue after a selection
  always @(posedge clock) begin : rd_model
    logic r, s, n;
    logic [5:0] a;
    logic [8:0] b0, b1;
    r = read_enable_n;
    s = read_address_strobe;
    n = nrst;
    a = read_queue_address;
    if (!n) begin
      cnt = 0;
      src = 4;
      foreach (mq[i]) mq[i].delete();
      exp_q.delete();
    end else begin
      if (!r && src < 4 && mq[src].size() >= (read_width_select ? 1 : 2)) begin
        b0 = mq[src].pop_front();
        b1 = read_width_select ? 9'h000 : mq[src].pop_front();
        exp_q.push_back({b1, b0});
      end
      if (cnt == 2) src = pend;
      if (cnt > 0) cnt--;
      if (s && cnt != 1) begin
        pend = (a[5:3] != tg || a[2]) ? 4 : int'(a[1:0]);
        cnt = 2;
      end
    end
  end

  always @(posedge clock) begin : mon
    logic r, n;
    logic [17:0] e;
    r = read_enable_n;
    n = nrst;
    #1;
    if (n && !r && word_valid_flag_n === 1'b0) begin
      e = 'x;
      if (exp_q.size() > 0) e = exp_q.pop_front();
      chk("read_data", 32'(e), 32'(read_data));
    end
  end

  always @(posedge clock) begin
    read_enable_n <= !rd_on || ($urandom_range(3) == 0);
    output_enable_n <= 1'($urandom);
  end

  initial begin
    #100000;
    fail_count++;
    final_report();
  end

  initial begin : main
    logic [31:0] v;
    int          u;
    void'($urandom(32'h4AD327AD));
    tg = 3'($urandom);
    write_queue_address <= 5'h00;
    write_address_strobe <= 1'b0;
    full_flag_bus_strobe <= 1'b0;
    write_enable_n <= 1'b1;
    write_data <= 18'h00000;
    avs_address <= 6'h00;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_writedata <= 32'h0;
    go <= 1'b0;
    flag_op <= 1'b0;
    addr <= 6'h00;
    rd_on <= 1'b0;
    for (int m = 0; m < 4; m++) begin
      nrst <= 1'b0;
      {write_width_select, read_width_select} <= 2'(m);
      repeat (20) @(posedge clock);
      nrst <= 1'b1;
      @(posedge clock);
      wr(tg, 2'h0, 3);
      wr(tg, 2'h1, 4);
      wr(tg ^ 3'h4, 2'h2, 2);
      wr(tg, 2'h3, 2);
      bus(1'b0, 6'h08, 32'h0, v);
      chk("level0", 32'(mq[0].size()), v);
      bus(1'b0, 6'h04, 32'h0, v);
      chk("width", {30'h0, ~m[1:0]}, 32'(v[8:7]));
      bus(1'b0, 6'h3C, 32'h0, v);
      chk("unmapped", 32'h0, v);
      bus(1'b1, 6'h00, 32'h8, v);
      repeat (3) @(posedge clock);
      mq[3].delete();
      bus(1'b0, 6'h14, 32'h0, v);
      chk("level3", 32'h0, v);
      for (int i = 0; i < 4; i++) begin
        u = read_width_select ? mq[i].size() : mq[i].size() / 2;
        chk("ae_bus", 32'(u > 2), 32'(almost_empty_flag_bus_n[i]));
        u = 16 - mq[i].size();
        u = write_width_select ? u : u / 2;
        chk("af_bus", 32'(u > 2), 32'(almost_full_flag_bus_n[i]));
      end
      chk("full", 32'h1, 32'(full_flag_n));
      for (int k = 0; k < 2; k++) begin
        write_queue_address <= {tg ^ 3'(k), 2'h0};
        full_flag_bus_strobe <= 1'b1;
        sel(1'b1, {tg ^ 3'(k), 3'h0}, 1);
        full_flag_bus_strobe <= 1'b0;
        @(posedge clock);
      end
      rd_on <= 1'b1;
      sel(1'b0, {tg, 3'h0}, 6);
      sel(1'b0, {tg, 3'h1}, 1);
      sel(1'b0, {tg, 3'h0}, 8);
      sel(1'b0, {tg, 1'b1, 2'($urandom)}, 6);
      sel(1'b0, {tg, 3'h3}, 6);
      sel(1'b0, {tg, 3'h2}, 6);
      sel(1'b0, {tg ^ 3'h2, 3'h1}, 6);
      sel(1'b0, {tg, 3'h1}, 20);
      rd_on <= 1'b0;
      repeat (3) @(posedge clock);
      chk("pending", 32'h0, 32'(exp_q.size()));
      $display("test width mode %0d done", m);
    end
    final_report();
  end
endmodule : tb_top

`default_nettype wire
